// *** fpu_numeric_exception_logic.sv ***
// numeric exception logic: detection, flags, masked results, handler request
// Function
// RL1: flag divide of finite nonzero by zero
// RL2: zero-divide flag and mask at bit 2
// RL3: only divides, log2 and extract report it
// RL4: zero-divide: flag; default or handler, state kept
// RL5: masked divide gives infinity, xor sign
// RL6: masked log2 gives infinity, opposite sign
// RL7: masked extract: next minus infinity, top signed zero
// RL8: overflow on register or float store only
// RL9: overflow flag and mask at bit 3
// RL10: masked overflow default by rounding control
// RL11: unmasked memory overflow: flag, handler, nothing changes
// RL12: unmasked register overflow: exponent minus 24576
// RL13: scale overflowing again stores signed infinity
// RL14: underflow never on integer stores
// RL15: underflow flag and mask at bit 4
// RL16: unmasked memory underflow: flag, handler, no write
// RL17: unmasked register underflow: exponent plus 24576
// RL18: inexact flag and mask at bit 5
// RL19: plain inexact sets flag and round-up bit
// RL20: inexact with masked over/under: both flags
// RL21: inexact with unmasked register case: both flags
// RL22: unmasked memory over/under: no inexact, clear round-up
// RL23: exception flags stay set until software clears
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "fpu_exc_params.svh"
module fpu_numeric_exception_logic
   import fpu_exc_pkg::*;
#(
   parameter int ADDR_W = 12           // apb address width
)(
   input  wire logic              pclk,     // bus and core clock
   input  wire logic              presetn,  // async reset, active low
   input  wire logic              psel,     // apb select
   input  wire logic              penable,  // apb access phase
   input  wire logic              pwrite,   // apb write
   input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
   input  wire logic [31:0]       pwdata,   // apb write data
   output logic [31:0]            prdata,   // apb read data
   output logic                   pready,   // apb ready
   output logic                   pslverr,  // apb error
   input  wire logic              req_valid,// datapath report strobe
   input  wire exc_req_t          req,      // datapath report
   output logic                   rsp_valid,// decision strobe
   output exc_rsp_t               rsp,      // decision
   output logic                   handler_req // pulse to dispatch
);
   // the register map needs at least five address bits
   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W too small for register map");
   end

   // overview of the flow:
   // - the datapath strobes one report
   // - the report is held for a cycle
   // - defaults settle in that cycle
   // - flags and decision follow
   // - the decision leaves one edge on
   // reports arriving while busy are
   // dropped, so the datapath must
   // leave one idle cycle between
   // them; this keeps the logic flat
   // instead of adding a queue
   //
   // architectural words
   logic [15:0] fpu_status_word;   // sticky flags and round-up bit
   logic [15:0] fpu_control_word;  // masks and rounding control

   // report held one cycle while the default result registers settle
   typedef enum {st_idle, st_decide} stage_t;
   stage_t   stage;           // decision pipeline stage
   exc_req_t held;            // captured report
   ext_val_t zero_val;        // divide-by-zero destination
   ext_val_t zero_next;       // extract second register
   ext_val_t over_val;        // masked overflow default
   ext_val_t last_result;     // last decided destination value for software view
   logic [3:0] last_action;   // last decision summary

   fpu_default_result u_defaults (
      .pclk      (pclk),
      .presetn   (presetn),
      .req       (req),
      .rc        (fpu_control_word[`RC_MSB:`RC_LSB]),
      .zero_val  (zero_val),
      .zero_next (zero_next),
      .over_val  (over_val)
   );

   // detection works on the held copy
   // only, never on the live report,
   // because the live bus may already
   // carry the next instruction
   // precedence between events:
   // - divide-by-zero first
   // - then overflow
   // - then underflow
   // inexact rides along with the last
   // two but never with divide-by-zero
   //
   // condition decode on the held report
   logic divider_op;   // op may report divide-by-zero
   logic zero_ev;      // divide-by-zero event
   logic over_ev;      // overflow event
   logic under_ev;     // underflow event
   logic prec_ev;      // inexact event as reported
   logic m_zero, m_over, m_under, m_prec;
   always_comb begin
      divider_op = (held.op == op_divide) ||
                   (held.op == op_log2_multiply) ||
                   (held.op == op_exponent_extract); // RL3
      zero_ev  = divider_op && held.divisor_zero &&
                 held.dividend_nonzero; // RL1
      // integer stores never see these two; invalid is handled elsewhere
      over_ev  = !zero_ev && held.overflow &&
                 (held.op != op_store_int); // RL8
      under_ev = !zero_ev && !over_ev && held.underflow &&
                 (held.op != op_store_int); // RL14
      prec_ev  = !zero_ev && held.inexact;
      m_zero   = fpu_control_word[`BIT_ZERO];    // RL2
      m_over   = fpu_control_word[`BIT_OVER];    // RL9
      m_under  = fpu_control_word[`BIT_UNDER];   // RL15
      m_prec   = fpu_control_word[`BIT_INEXACT]; // RL18
   end

   // three outcomes are possible:
   // - masked: store a default value
   // - unmasked to memory: trap with
   //   nothing written to memory or stack
   // - unmasked to register: store a
   //   re-biased value, then trap
   // the round-up bit follows the
   // rounding only where it is kept;
   // a memory trap always clears it
   //
   // decision: which flags, which result, whether to trap
   logic     unm_mem;     // unmasked over/under to memory
   logic     unm_reg;     // unmasked over/under to register
   logic     set_zero, set_over, set_under, set_prec;
   logic     next_trap;   // handler request
   logic     next_wr;     // destination write
   logic     next_wr2;    // second register write
   logic     next_c1_set; // drive round-up bit
   logic     next_c1;     // round-up bit value
   ext_val_t next_dest;   // destination value
   always_comb begin
      unm_mem   = held.mem_dest && ((over_ev && !m_over) ||
                                    (under_ev && !m_under));
      unm_reg   = !held.mem_dest && ((over_ev && !m_over) ||
                                     (under_ev && !m_under));
      set_zero  = zero_ev;  // RL4
      set_over  = over_ev;  // RL11
      set_under = under_ev; // RL16
      set_prec  = prec_ev && !unm_mem; // RL22
      next_trap = 1'b0;
      next_wr   = 1'b1;
      next_wr2  = 1'b0;
      next_c1_set = 1'b0;
      next_c1   = 1'b0;
      next_dest = held.result;
      if (zero_ev) begin
         if (m_zero) begin
            next_dest = zero_val; // RL4
            next_wr2  = (held.op == op_exponent_extract); // RL7
         end else begin
            next_wr   = 1'b0; // RL4
            next_trap = 1'b1;
         end
      end else if (unm_mem) begin
         // memory untouched, stack kept, round-up cleared
         next_wr     = 1'b0; // RL11 RL16
         next_trap   = 1'b1;
         next_c1_set = 1'b1;
         next_c1     = 1'b0; // RL22
      end else if (unm_reg) begin
         next_c1_set = 1'b1;
         next_c1     = held.rounded_up;
         next_trap   = 1'b1; // RL21
         if (over_ev) begin
            if (held.op == op_scale && held.overflow_again)
               next_dest = '{sign: held.result.sign,
                             exp: `EXP_ALL_ONES,
                             sig: 64'h8000000000000000}; // RL13
            else
               next_dest.exp = held.result.exp - `EXP_BIAS_ADJ; // RL12
         end else begin
            if (held.op == op_scale && held.underflow_again)
               next_dest = '{sign: held.result.sign, exp: 15'h0000,
                             sig: 64'h0}; // RL17
            else
               next_dest.exp = held.result.exp + `EXP_BIAS_ADJ; // RL17
         end
      end else begin
         if (over_ev)
            next_dest = over_val; // RL10
         // masked under: datapath already delivered the denormal result
         if (prec_ev) begin
            next_c1_set = 1'b1;
            next_c1     = held.rounded_up; // RL19
            if (!m_prec)
               next_trap = 1'b1; // RL19 RL20
         end
      end
   end

   // writes commit on the access edge
   // only; the setup cycle is used by
   // the read path to fetch data early
   // so that no wait state is needed
   //
   // apb decode
   logic acc;        // access phase of a transfer
   logic wr_status;  // software write to status
   logic wr_control; // software write to control
   always_comb begin
      acc        = psel && penable;
      wr_status  = acc && pwrite && (paddr == `REG_STATUS_OFF);
      wr_control = acc && pwrite && (paddr == `REG_CONTROL_OFF);
   end

   // report capture and two-step pipeline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage <= st_idle;
         held  <= '0;
      end else begin
         case (stage)
            st_idle: begin
               if (req_valid) begin
                  held  <= req;
                  stage <= st_decide;
               end
            end
            st_decide: stage <= st_idle;
            default:   stage <= st_idle;
         endcase
      end
   end

   // flags are sticky: software clears
   // them by writing zero, hardware only
   // ever sets them; if both land in one
   // cycle the set survives so no event
   // can be lost to a racing clear
   //
   // status word: hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fpu_status_word <= `STATUS_RESET;
      end else begin
         logic [15:0] nxt;
         nxt = fpu_status_word;
         if (wr_status)
            nxt = (nxt & ~`STATUS_SW_MASK) |
                  (pwdata[15:0] & `STATUS_SW_MASK);
         if (stage == st_decide) begin
            if (set_zero)  nxt[`BIT_ZERO]    = 1'b1; // RL23
            if (set_over)  nxt[`BIT_OVER]    = 1'b1; // RL23
            if (set_under) nxt[`BIT_UNDER]   = 1'b1; // RL23
            if (set_prec)  nxt[`BIT_INEXACT] = 1'b1; // RL20 RL23
            if (next_c1_set) nxt[`BIT_ROUND_UP] = next_c1;
         end
         fpu_status_word <= nxt;
      end
   end

   // control word written only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         fpu_control_word <= `CONTROL_RESET;
      else if (wr_control)
         fpu_control_word <= pwdata[15:0];
   end

   // the decision fields hold until the
   // next one, so a slow consumer may
   // read them after the strobe is gone
   //
   // decision outputs, one-cycle strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid   <= 1'b0;
         rsp         <= '0;
         handler_req <= 1'b0;
         last_result <= '0;
         last_action <= 4'h0;
      end else begin
         rsp_valid   <= (stage == st_decide);
         handler_req <= (stage == st_decide) && next_trap;
         if (stage == st_decide) begin
            rsp.write_dest  <= next_wr;
            rsp.write_next  <= next_wr2;
            rsp.handler_req <= next_trap;
            rsp.keep_state  <= next_trap && !next_wr; // RL4 RL11
            rsp.dest_val    <= next_dest;
            rsp.next_val    <= zero_next;
            last_result     <= next_dest;
            last_action     <= {next_trap, next_wr, next_wr2,
                                next_c1};
         end
      end
   end

   // read data come from a register set
   // in the setup cycle; a flag set by
   // the same edge shows on later reads
   //
   // apb slave: zero wait, unmapped reads zero with error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `REG_STATUS_OFF:    prdata <= {16'h0000, fpu_status_word};
               `REG_CONTROL_OFF:   prdata <= {16'h0000, fpu_control_word};
               `REG_RESULT_LO_OFF: prdata <= last_result.sig[31:0];
               `REG_RESULT_HI_OFF: prdata <= last_result.sig[63:32];
               `REG_ACTION_OFF:    prdata <= {12'h000, last_action,
                                              last_result.sign,
                                              last_result.exp};
               default:            pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule : fpu_numeric_exception_logic

// *** fpu_exc_params.svh ***
// constants for the numeric exception block
`ifndef FPU_EXC_PARAMS_SVH
`define FPU_EXC_PARAMS_SVH
`define REG_STATUS_OFF     12'h000
`define REG_CONTROL_OFF    12'h004
`define REG_RESULT_LO_OFF  12'h008
`define REG_RESULT_HI_OFF  12'h00c
`define REG_ACTION_OFF     12'h010
`define BIT_ZERO           2
`define BIT_OVER           3
`define BIT_UNDER          4
`define BIT_INEXACT        5
`define BIT_ROUND_UP       9
`define STATUS_RESET       16'h0000
`define CONTROL_RESET      16'h003f
`define STATUS_SW_MASK     16'h023c
`define EXP_BIAS_ADJ       15'h6000
`define EXP_ALL_ONES       15'h7fff
`define RC_NEAREST         2'h0
`define RC_DOWN            2'h1
`define RC_UP              2'h2
`define RC_ZERO            2'h3
`define RC_LSB             10
`define RC_MSB             11
`endif

// *** fpu_exc_pkg.sv ***
// types shared by the numeric exception block
package fpu_exc_pkg;
   // operation classes reported by the datapath
   typedef enum logic [2:0] {
      op_other,
      op_divide,
      op_log2_multiply,
      op_exponent_extract,
      op_scale,
      op_store_float,
      op_store_int
   } op_class_t;
   // one extended value: sign, exponent, significand
   typedef struct packed {
      logic        sign;
      logic [14:0] exp;
      logic [63:0] sig;
   } ext_val_t;
   // condition report from the datapath for one instruction
   typedef struct packed {
      op_class_t op;
      logic      mem_dest;
      logic      dividend_nonzero;
      logic      divisor_zero;
      logic      overflow;
      logic      underflow;
      logic      overflow_again;
      logic      underflow_again;
      logic      inexact;
      logic      rounded_up;
      logic      src_sign;
      logic      other_sign;
      ext_val_t  result;
   } exc_req_t;
   // decision returned to datapath and dispatch
   typedef struct packed {
      logic     write_dest;
      logic     write_next;
      logic     handler_req;
      logic     keep_state;
      ext_val_t dest_val;
      ext_val_t next_val;
   } exc_rsp_t;
endpackage : fpu_exc_pkg

// *** fpu_default_result.sv ***
// masked default results for divide-by-zero and overflow
`timescale 1ns/100ps
`include "fpu_exc_params.svh"
module fpu_default_result
   import fpu_exc_pkg::*;
(
   input  wire logic      pclk,       // bus clock
   input  wire logic      presetn,    // async reset, active low
   input  wire exc_req_t  req,        // condition report
   input  wire logic [1:0] rc,        // rounding control
   output ext_val_t       zero_val,   // registered divide-by-zero value
   output ext_val_t       zero_next,  // registered second stack value
   output ext_val_t       over_val    // registered masked overflow value
);
   // infinity and largest finite patterns
   function automatic ext_val_t inf_of(input logic s);
      inf_of = '{sign: s, exp: `EXP_ALL_ONES, sig: 64'h8000000000000000};
   endfunction : inf_of
   function automatic ext_val_t max_of(input logic s);
      max_of = '{sign: s, exp: 15'h7ffe, sig: 64'hffffffffffffffff};
   endfunction : max_of

   // registered results keep combinational depth off the caller's path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_val  <= '0;
         zero_next <= '0;
         over_val  <= '0;
      end else begin
         case (req.op)
            op_log2_multiply: begin
               zero_val <= inf_of(~req.src_sign); // RL6
            end
            op_exponent_extract: begin
               zero_val <= '{sign: req.src_sign, exp: 15'h0000,
                             sig: 64'h0}; // RL7
            end
            default: begin
               zero_val <= inf_of(req.src_sign ^ req.other_sign); // RL5
            end
         endcase
         zero_next <= inf_of(1'b1); // RL7
         // overflow default follows rounding direction and sign
         case (rc)
            `RC_NEAREST: over_val <= inf_of(req.result.sign); // RL10
            `RC_DOWN:    over_val <= req.result.sign ? inf_of(1'b1)
                                                     : max_of(1'b0);
            `RC_UP:      over_val <= req.result.sign ? max_of(1'b1)
                                                     : inf_of(1'b0);
            default:     over_val <= max_of(req.result.sign);
         endcase
      end
   end
endmodule : fpu_default_result

// *** fpu_exc_chk.sv ***
// port assertions for the numeric exception block
`timescale 1ns/100ps
module fpu_exc_chk
   import fpu_exc_pkg::*;
#(
   parameter int ADDR_W = 12  // apb address width
)(
   input wire logic              pclk,       // clock
   input wire logic              presetn,    // reset, active low
   input wire logic              psel,       // select
   input wire logic              penable,    // access phase
   input wire logic              pwrite,     // write
   input wire logic [ADDR_W-1:0] paddr,      // address
   input wire logic [31:0]       pwdata,     // write data
   input wire logic [31:0]       prdata,     // read data
   input wire logic              pready,     // ready
   input wire logic              pslverr,    // error
   input wire logic              req_valid,  // report strobe
   input wire exc_req_t          req,        // report
   input wire logic              rsp_valid,  // decision strobe
   input wire exc_rsp_t          rsp,        // decision
   input wire logic              handler_req // trap pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a fresh report is answered two edges later
   a_rsp_latency: assert property (req_valid && !$past(req_valid) &&
      !$past(req_valid, 2) |-> ##2 rsp_valid) else $error("no decision");
   a_rsp_cause: assert property (rsp_valid |-> $past(req_valid, 2))
      else $error("decision without report");
   a_trap_pulse: assert property (handler_req == (rsp_valid && rsp.handler_req))
      else $error("trap pulse differs from decision");
   // a trap that writes nothing must freeze stack and operands
   a_keep_state: assert property (rsp_valid |-> rsp.keep_state ==
      (rsp.handler_req && !rsp.write_dest)) else $error("keep state wrong");
   a_zero_inf: assert property (req_valid && req.op == op_divide &&
      req.dividend_nonzero && req.divisor_zero |-> ##2 (rsp.handler_req ||
      (rsp.dest_val.exp == 15'h7fff && rsp.dest_val.sign ==
      ($past(req.src_sign, 2) ^ $past(req.other_sign, 2)))))
      else $error("masked zero divide result wrong");
   // inexact kept out so only an unmasked over/underflow can trap here
   a_mem_trap: assert property (req_valid && req.mem_dest && !req.inexact
      && (req.overflow || req.underflow) && !req.divisor_zero |->
      ##2 (!rsp.handler_req || !rsp.write_dest)) else $error("memory written");
   a_rebias_over: assert property (req_valid && req.op == op_other &&
      !req.mem_dest && req.overflow && !req.overflow_again && !req.inexact
      && !req.divisor_zero |-> ##2 (!rsp.handler_req || rsp.dest_val.exp ==
      15'($past(req.result.exp, 2) - 15'h6000))) else $error("over bias");
   a_rebias_under: assert property (req_valid && req.op == op_other &&
      !req.mem_dest && req.underflow && !req.underflow_again && !req.inexact
      && !req.overflow && !req.divisor_zero |-> ##2 (!rsp.handler_req ||
      rsp.dest_val.exp == 15'($past(req.result.exp, 2) + 15'h6000)))
      else $error("under bias");
   a_int_store: assert property (req_valid && req.op == op_store_int &&
      !req.inexact && !req.divisor_zero |-> ##2 (rsp_valid &&
      !rsp.handler_req)) else $error("integer store trapped");
   a_apb_ready: assert property (psel && !penable |=> pready && penable)
      else $error("no ready after setup");
   a_unmapped: assert property (psel && !penable && paddr > 'h10 |=>
      pslverr && prdata == 32'h0) else $error("unmapped not refused");
endmodule : fpu_exc_chk
bind fpu_numeric_exception_logic fpu_exc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** fpu_datapath_model.sv ***
// datapath model that hands reports to the exception block
`timescale 1ns/100ps
module fpu_datapath_model
   import fpu_exc_pkg::*;
(
   input  wire logic pclk,      // clock
   output logic      req_valid, // report strobe
   output exc_req_t  req        // report
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // one pulse, then the bus shows junk so stale data is not trusted
   task automatic send(input exc_req_t r);
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= r;
      @(posedge pclk);
      req_valid <= 1'b0;
      req <= ~r;
      repeat (4) @(posedge pclk);
   endtask : send
endmodule : fpu_datapath_model

// *** tb_top.sv ***
// self-checking bench for the numeric exception block
`timescale 1ns/100ps
module tb_top
   import fpu_exc_pkg::*;
;
   logic        pclk = 1'b0;    // clock
   logic        presetn = 1'b0; // reset, active low
   logic        psel = 1'b0;    // select
   logic        penable = 1'b0; // access phase
   logic        pwrite = 1'b0;  // write
   logic [11:0] paddr = '0;     // address
   logic [31:0] pwdata = '0;    // write data
   logic [31:0] prdata;         // read data
   logic        pready;         // ready
   logic        pslverr;        // error
   logic        req_valid;      // report strobe
   exc_req_t    req;            // report
   logic        rsp_valid;      // decision strobe
   exc_rsp_t    rsp;            // decision
   logic        handler_req;    // trap pulse
   int          miscompares = 0;
   int          checks = 0;
   logic [64:0] rd_q[$];        // {err, mask, data} per read
   logic [35:0] rs_q[$];        // {care, trap, wr, wrn, dest, next}
   logic [64:0] e;
   logic [35:0] r;
   always #25 pclk = ~pclk;
   fpu_numeric_exception_logic dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
      .handler_req(handler_req));
   fpu_datapath_model u_dp (.pclk(pclk), .req_valid(req_valid), .req(req));
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // apb master; a read notes its expected word first
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, m);
      if (!w) rd_q.push_back({a > 12'h010, m, d});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic op(input exc_req_t q, input logic [35:0] x);
      rs_q.push_back(x);
      u_dp.send(q);
   endtask : op
   // report with random signs and result; f = mem,dz,ov,un,ova,una,ix,ru
   function automatic exc_req_t mk(op_class_t o, logic [7:0] f);
      exc_req_t q;
      q = '0;
      q.op = o;
      q.dividend_nonzero = 1'b1;
      {q.mem_dest, q.divisor_zero, q.overflow, q.underflow, q.overflow_again,
       q.underflow_again, q.inexact, q.rounded_up} = f;
      {q.src_sign, q.other_sign} = 2'($urandom);
      q.result = ext_val_t'({$urandom, $urandom, 16'($urandom)});
      return q;
   endfunction : mk
   // monitor: each result takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
         e = rd_q.pop_front();
         check("read", prdata & e[63:32], e[31:0]);
         check("slverr", 32'(pslverr), 32'(e[64]));
      end
      if (rsp_valid && rs_q.size() > 0) begin
         r = rs_q.pop_front();
         check("trap", 32'(handler_req), 32'(r[34]));
         if (r[35]) check("wr", 32'({rsp.write_dest, rsp.write_next}),
            32'(r[33:32]));
         if (r[35] && r[33]) check("dest", 32'({rsp.dest_val.sign,
            rsp.dest_val.exp}), 32'(r[31:16]));
         if (r[35] && r[32]) check("next", 32'({rsp.next_val.sign,
            rsp.next_val.exp}), 32'(r[15:0]));
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      test_done();
   end
   initial begin
      exc_req_t   q;
      logic [14:0] x;
      void'($urandom(32'h6083));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h004, 32'h003f, 32'hffff);
      apb(0, 12'h000, 32'h0, 32'hffff);
      apb(0, 12'h014, 32'h0, 32'hffffffff);
      op(mk(op_other, 8'h40), 36'h0);
      op(mk(op_scale, 8'h40), 36'h0);
      apb(0, 12'h000, 32'h0, 32'h3c);
      for (int i = 0; i < 4; i++) begin
         q = mk(op_divide, 8'h40);
         op(q, {4'b1010, q.src_sign ^ q.other_sign, 15'h7fff, 16'h0});
      end
      apb(1, 12'h004, 32'h003b, 32'h0);
      op(mk(op_divide, 8'h40), {4'b1100, 32'h0});
      apb(1, 12'h004, 32'h003f, 32'h0);
      q = mk(op_log2_multiply, 8'h40);
      q.other_sign = q.src_sign;
      op(q, {4'b1010, ~q.src_sign, 15'h7fff, 16'h0});
      q = mk(op_exponent_extract, 8'h40);
      op(q, {4'b1011, q.src_sign, 15'h0, 16'hffff});
      for (int i = 0; i < 4; i++) begin
         apb(1, 12'h004, {20'h0, 2'(i), 10'h03f}, 32'h0);
         q = mk(op_other, 8'h22);
         x = (i == 0 || (i == 1) == q.result.sign) ? 15'h7fff : 15'h7ffe;
         if (i == 3) x = 15'h7ffe;
         op(q, {4'b1010, q.result.sign, x, 16'h0});
      end
      apb(0, 12'h000, 32'h2c, 32'h3c);
      apb(1, 12'h000, 32'h0, 32'h0);
      apb(1, 12'h004, 32'h0037, 32'h0);
      q = mk(op_other, 8'h23);
      op(q, {4'b1110, q.result.sign, 15'(q.result.exp - 15'h6000),
         16'h0});
      apb(0, 12'h000, 32'h228, 32'h23c);
      q = mk(op_scale, 8'h2a);
      op(q, {4'b1110, q.result.sign, 15'h7fff, 16'h0});
      apb(1, 12'h000, 32'h200, 32'h0);
      op(mk(op_store_float, 8'ha3), {4'b1100, 32'h0});
      apb(0, 12'h000, 32'h08, 32'h23c);
      apb(1, 12'h000, 32'h0, 32'h0);
      apb(1, 12'h004, 32'h002f, 32'h0);
      q = mk(op_other, 8'h12);
      op(q, {4'b1110, q.result.sign, 15'(q.result.exp + 15'h6000),
         16'h0});
      apb(0, 12'h000, 32'h30, 32'h23c);
      q = mk(op_scale, 8'h16);
      op(q, {4'b1110, q.result.sign, 15'h0, 16'h0});
      op(mk(op_store_float, 8'h90), {4'b1100, 32'h0});
      apb(1, 12'h000, 32'h0, 32'h0);
      apb(1, 12'h004, 32'h0027, 32'h0);
      op(mk(op_store_int, 8'h30), 36'h0);
      apb(0, 12'h000, 32'h0, 32'h18);
      apb(1, 12'h004, 32'h001f, 32'h0);
      op(mk(op_other, 8'h03), {4'b0100, 32'h0});
      apb(0, 12'h000, 32'h220, 32'h23c);
      op(mk(op_other, 8'h02), {4'b0100, 32'h0});
      apb(0, 12'h000, 32'h020, 32'h23c);
      op(mk(op_other, 8'h22), {4'b0100, 32'h0});
      repeat (5) @(posedge pclk);
      test_done();
   end
endmodule : tb_top
